// ==== inc/scr_pkg.sv ====
package scr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_ZERO   = 8'h00;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE   = 8'h04;
    localparam logic [7:0] ADDR_ROUTE   = 8'h08;
    localparam logic [7:0] ADDR_WAKE    = 8'h0c;
    localparam logic [7:0] ADDR_PULLUP  = 8'h10;
    localparam logic [7:0] ADDR_LCDCOM  = 8'h14;
    localparam logic [7:0] ADDR_DIR     = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1c;

    // Field positions
    localparam int CLKMODE_BIT = 0;
    localparam int XTALLP_BIT  = 1;
    localparam int PINEN_BIT   = 2;
    localparam int CLKSEL_BIT  = 6;

    // Writable masks
    localparam logic [7:0] SYSTEM_CONTROL_ZERO_MASK_SMALL = 8'h07;
    localparam logic [7:0] SYSTEM_CONTROL_ZERO_MASK_LARGE = 8'h47;
    localparam logic [7:0] ROUTE_MASK       = 8'h0c;

    // Reset values
    localparam logic [7:0] SYSTEM_CONTROL_ZERO_RST  = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_ONE_RST  = 8'h8a;
    localparam logic [7:0] ROUTE_RST  = 8'h00;
    localparam logic [7:0] WAKE_RST   = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] LCDCOM_RST = 8'h00;
    localparam logic [7:0] DIR_RST    = 8'hff;

    localparam logic [3:0] WDT_OFF_CODE = 4'ha;

    // Time base exponents
    localparam int TB_BASE_EXP = 10;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Variants
    localparam int VAR_SMALL  = 0;
    localparam int VAR_MIDDLE = 1;
    localparam int VAR_LARGE  = 2;

    // Routed function locations: port index 0=A,1=B,2=C, bit index
    typedef struct packed {
        logic [1:0] port;
        logic [2:0] bit_idx;
    } scr_loc_t;
endpackage

// ==== src/scr_regs.sv ====
// Notes on behaviour
// - Divider source bit picks timer0 or timer1
// - Pin-enable bit puts divider output on pin
// - Crystal power bit: quick start or low power
// - Clock-mode bit: fast RC or crystal, RC stops
// - Clock selections valid only in RC+crystal option
// - Edge field: off, rising, falling, both
// - Time base period 2^10 to 2^13 source cycles
// - Watchdog off only for code 1010
// - Always-on option overrides watchdog code
// - Small variant three routing codes
// - Middle variant codes 00 and 11 only
// - Large variant four routing codes
// - Unimplemented bits ignore writes, read zero
// - Falling edge on wake pin ends sleep
// - Pull-ups only on pins set as input
// - LCD common control sets bias on four pins
// - Oscillators also clock watchdog and time base
// - Direction bit high input, low output
//
// The register offsets and the AXI4-Lite register port were decided locally.
module scr_regs #(
    parameter int VARIANT = 2
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cfg_rc_xtal_option,
    input  wire logic        cfg_wdt_always_on,
    input  wire logic        sleeping,
    input  wire logic [7:0]  porta_pin_in,
    input  wire logic        timer0_freq_out,
    input  wire logic        timer1_freq_out,
    output logic             freq_out_pin_enable,
    output logic             prog_freq_divider_out,
    output logic             slow_xtal_low_power,
    output logic             sysclk_slow_select,
    output logic             fast_internal_rc_enable,
    output logic [1:0]       ext_irq_edge_mode,
    output logic [13:0]      timebase_period,
    output logic             watchdog_enable,
    output logic             watchdog_clk_slow,
    output logic [1:0]       pin_route_sel,
    output logic [4:0]       route_irq_loc,
    output logic [4:0]       route_timer0_loc,
    output logic [4:0]       route_timer1_loc,
    output logic [4:0]       route_freq_loc,
    output logic             wake_request,
    output logic [7:0]       porta_pullup_active,
    output logic [7:0]       porta_dir_input,
    output logic [7:0]       soft_lcd_common_ctrl
);
    initial begin
        if (VARIANT < scr_pkg::VAR_SMALL || VARIANT > scr_pkg::VAR_LARGE) begin
            $error("VARIANT out of range");
        end
    end

    localparam logic [7:0] SYSTEM_CONTROL_ZERO_MASK = (VARIANT == scr_pkg::VAR_SMALL) ?
        scr_pkg::SYSTEM_CONTROL_ZERO_MASK_SMALL : scr_pkg::SYSTEM_CONTROL_ZERO_MASK_LARGE;

    logic [7:0] system_control_zero_q;
    logic [7:0] system_control_one_q;
    logic [7:0] route_q;
    logic [7:0] wake_q;
    logic [7:0] pullup_q;
    logic [7:0] lcdcom_q;
    logic [7:0] dir_q;
    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic       wstrb0_q;
    logic [7:0] pa_sync1_q;
    logic [7:0] pa_sync2_q;
    logic [7:0] pa_prev_q;
    logic       t0_sync1_q;
    logic       t0_sync2_q;
    logic       t1_sync1_q;
    logic       t1_sync2_q;
    logic       do_write;
    logic       wr_hit;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == scr_pkg::ADDR_SYSTEM_CONTROL_ZERO) || (a == scr_pkg::ADDR_SYSTEM_CONTROL_ONE) ||
                     (a == scr_pkg::ADDR_ROUTE) || (a == scr_pkg::ADDR_WAKE) ||
                     (a == scr_pkg::ADDR_PULLUP) || (a == scr_pkg::ADDR_LCDCOM) ||
                     (a == scr_pkg::ADDR_DIR) || (a == scr_pkg::ADDR_STATUS);
    endfunction

    function automatic scr_loc_pack(input logic [1:0] p, input logic [2:0] b);
        scr_loc_pack = 1'b0;
    endfunction

    // Address and data may arrive in either order; each is held once taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 8'h00;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit   = do_write && wstrb0_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= scr_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(awaddr_q) ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register file; masks drop unimplemented bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_control_zero_q  <= scr_pkg::SYSTEM_CONTROL_ZERO_RST;
            system_control_one_q  <= scr_pkg::SYSTEM_CONTROL_ONE_RST;
            route_q  <= scr_pkg::ROUTE_RST;
            wake_q   <= scr_pkg::WAKE_RST;
            pullup_q <= scr_pkg::PULLUP_RST;
            lcdcom_q <= scr_pkg::LCDCOM_RST;
            dir_q    <= scr_pkg::DIR_RST;
        end else if (wr_hit) begin
            case (awaddr_q)
                scr_pkg::ADDR_SYSTEM_CONTROL_ZERO:  system_control_zero_q  <= wdata_q & SYSTEM_CONTROL_ZERO_MASK;
                scr_pkg::ADDR_SYSTEM_CONTROL_ONE:  system_control_one_q  <= wdata_q;
                scr_pkg::ADDR_ROUTE:  route_q  <= wdata_q & scr_pkg::ROUTE_MASK;
                scr_pkg::ADDR_WAKE:   wake_q   <= wdata_q;
                scr_pkg::ADDR_PULLUP: pullup_q <= wdata_q;
                scr_pkg::ADDR_LCDCOM: lcdcom_q <= wdata_q;
                scr_pkg::ADDR_DIR:    dir_q    <= wdata_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= scr_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= addr_known(s_axi_araddr) ? scr_pkg::RESP_OKAY
                                                         : scr_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    scr_pkg::ADDR_SYSTEM_CONTROL_ZERO:  s_axi_rdata <= {24'h000000, system_control_zero_q};
                    scr_pkg::ADDR_SYSTEM_CONTROL_ONE:  s_axi_rdata <= {24'h000000, system_control_one_q};
                    scr_pkg::ADDR_ROUTE:  s_axi_rdata <= {24'h000000, route_q};
                    scr_pkg::ADDR_WAKE:   s_axi_rdata <= {24'h000000, wake_q};
                    scr_pkg::ADDR_PULLUP: s_axi_rdata <= {24'h000000, pullup_q};
                    scr_pkg::ADDR_LCDCOM: s_axi_rdata <= {24'h000000, lcdcom_q};
                    scr_pkg::ADDR_DIR:    s_axi_rdata <= {24'h000000, dir_q};
                    scr_pkg::ADDR_STATUS: s_axi_rdata <= {28'h0000000, wake_request,
                        watchdog_enable, sysclk_slow_select, fast_internal_rc_enable};
                    default:              s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin and timer inputs come from other clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_sync1_q <= 8'hff;
            pa_sync2_q <= 8'hff;
            pa_prev_q  <= 8'hff;
            t0_sync1_q <= 1'b0;
            t0_sync2_q <= 1'b0;
            t1_sync1_q <= 1'b0;
            t1_sync2_q <= 1'b0;
        end else begin
            pa_sync1_q <= porta_pin_in;
            pa_sync2_q <= pa_sync1_q;
            pa_prev_q  <= pa_sync2_q;
            t0_sync1_q <= timer0_freq_out;
            t0_sync2_q <= t0_sync1_q;
            t1_sync1_q <= timer1_freq_out;
            t1_sync2_q <= t1_sync1_q;
        end
    end

    // Outputs registered so a write shows one cycle later, free of glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_out_pin_enable     <= 1'b0;
            prog_freq_divider_out   <= 1'b0;
            slow_xtal_low_power     <= 1'b0;
            sysclk_slow_select      <= 1'b0;
            fast_internal_rc_enable <= 1'b1;
            ext_irq_edge_mode       <= 2'b10;
            timebase_period         <= 14'h0400;
            watchdog_enable         <= 1'b1;
            watchdog_clk_slow       <= 1'b0;
            pin_route_sel           <= 2'b00;
            wake_request            <= 1'b0;
            porta_pullup_active     <= 8'h00;
            porta_dir_input         <= scr_pkg::DIR_RST;
            soft_lcd_common_ctrl    <= 8'h00;
        end else begin
            freq_out_pin_enable <= system_control_zero_q[scr_pkg::PINEN_BIT];
            if (!system_control_zero_q[scr_pkg::PINEN_BIT]) begin
                prog_freq_divider_out <= 1'b0;
            end else if (VARIANT != scr_pkg::VAR_SMALL && system_control_zero_q[scr_pkg::CLKSEL_BIT]) begin
                prog_freq_divider_out <= t1_sync2_q;
            end else begin
                prog_freq_divider_out <= t0_sync2_q;
            end
            // Ignored unless the RC plus crystal option is fitted
            slow_xtal_low_power <= cfg_rc_xtal_option && system_control_zero_q[scr_pkg::XTALLP_BIT];
            sysclk_slow_select  <= cfg_rc_xtal_option && system_control_zero_q[scr_pkg::CLKMODE_BIT];
            fast_internal_rc_enable <=
                !(cfg_rc_xtal_option && system_control_zero_q[scr_pkg::CLKMODE_BIT]);
            ext_irq_edge_mode   <= system_control_one_q[7:6];
            timebase_period     <= 14'(14'h0001 << (scr_pkg::TB_BASE_EXP + system_control_one_q[5:4]));
            watchdog_enable     <= cfg_wdt_always_on ||
                                   (system_control_one_q[3:0] != scr_pkg::WDT_OFF_CODE);
            watchdog_clk_slow   <= cfg_rc_xtal_option && system_control_zero_q[scr_pkg::CLKMODE_BIT];
            pin_route_sel       <= route_q[3:2];
            // Falling edge on a selected port A pin while asleep
            wake_request        <= sleeping &&
                                   |(wake_q & pa_prev_q & ~pa_sync2_q);
            porta_pullup_active <= pullup_q & dir_q;
            porta_dir_input     <= dir_q;
            soft_lcd_common_ctrl <= lcdcom_q;
        end
    end

    // Locations as {port[1:0], bit[2:0]}: A=0, B=1, C=2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_irq_loc    <= 5'h00;
            route_timer0_loc <= 5'h02;
            route_timer1_loc <= 5'h06;
            route_freq_loc   <= 5'h01;
        end else begin
            route_irq_loc    <= 5'h00;
            route_timer0_loc <= 5'h02;
            route_timer1_loc <= 5'h06;
            route_freq_loc   <= 5'h01;
            if (VARIANT == scr_pkg::VAR_SMALL) begin
                case (route_q[3:2])
                    2'b01:   route_irq_loc <= 5'h03;
                    2'b10: begin
                        route_irq_loc    <= 5'h09;
                        route_timer0_loc <= 5'h0a;
                        route_freq_loc   <= 5'h08;
                    end
                    default: ;
                endcase
            end else begin
                case (route_q[3:2])
                    2'b01: begin
                        if (VARIANT == scr_pkg::VAR_LARGE) begin
                            route_irq_loc    <= 5'h03;
                            route_timer1_loc <= 5'h04;
                        end
                    end
                    2'b10: begin
                        if (VARIANT == scr_pkg::VAR_LARGE) begin
                            route_timer1_loc <= 5'h04;
                        end
                    end
                    2'b11: begin
                        route_irq_loc    <= 5'h13;
                        route_timer0_loc <= 5'h14;
                        route_freq_loc   <= 5'h12;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ==== verif/scr_regs_checker.sv ====
module scr_regs_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        cfg_rc_xtal_option,
    input wire logic        cfg_wdt_always_on,
    input wire logic        freq_out_pin_enable,
    input wire logic        prog_freq_divider_out,
    input wire logic        slow_xtal_low_power,
    input wire logic        sysclk_slow_select,
    input wire logic        fast_internal_rc_enable,
    input wire logic [1:0]  ext_irq_edge_mode,
    input wire logic [13:0] timebase_period,
    input wire logic        watchdog_enable,
    input wire logic        watchdog_clk_slow,
    input wire logic [1:0]  pin_route_sel,
    input wire logic        wake_request,
    input wire logic [7:0]  porta_pullup_active,
    input wire logic [7:0]  porta_dir_input
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Own disable so the reset cycle itself is judged
    reset_defaults_a: assert property (disable iff (1'b0) !aresetn |=> timebase_period == 14'd1024 && ext_irq_edge_mode == 2'b10 && pin_route_sel == 2'b00) else $error("defaults wrong after reset");
    rc_stops_a: assert property (fast_internal_rc_enable != sysclk_slow_select) else $error("fast rc runs with slow clock");
    option_gates_a: assert property (!cfg_rc_xtal_option [*2] |-> !sysclk_slow_select && !slow_xtal_low_power) else $error("clock bits act without option");
    wdt_forced_a: assert property (cfg_wdt_always_on [*2] |-> watchdog_enable) else $error("watchdog off with always-on option");
    period_range_a: assert property ($onehot(timebase_period) && timebase_period[9:0] == 10'h000) else $error("time base period out of range");
    divider_idle_a: assert property (!freq_out_pin_enable [*2] |-> !prog_freq_divider_out) else $error("divider output while pin is io");
    write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:4] s_axi_bvalid) else $error("write not answered");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
    wake_pulse_a: assert property (wake_request |=> !wake_request) else $error("wake request longer than a cycle");
    pullup_input_a: assert property ($stable(porta_dir_input) |-> (porta_pullup_active & ~porta_dir_input) == 8'h00) else $error("pull-up on output pin");
    wdt_clock_a: assert property (watchdog_clk_slow == sysclk_slow_select) else $error("watchdog clock differs from system clock");
endmodule

bind scr_regs scr_regs_checker scr_regs_checker_inst (.*);

// ==== verif/test_system_control_registers.sv ====
module test_system_control_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, porta_pin_in, porta_pullup_active, porta_dir_input;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, ext_irq_edge_mode, pin_route_sel;
    logic cfg_rc_xtal_option, cfg_wdt_always_on, sleeping, timer0_freq_out, timer1_freq_out;
    logic freq_out_pin_enable, prog_freq_divider_out, slow_xtal_low_power, sysclk_slow_select;
    logic fast_internal_rc_enable, watchdog_enable, watchdog_clk_slow, wake_request;
    logic [13:0] timebase_period;
    logic [4:0] route_irq_loc, route_timer0_loc, route_timer1_loc, route_freq_loc;
    logic [7:0] soft_lcd_common_ctrl;
    logic [1:0] rsp;
    logic [31:0] rd;
    int fails = 0;
    int comparisons = 0;
    // Large variant locations {irq, timer0, timer1, divider}
    logic [19:0] locs [4] = '{20'h008c1, 20'h18881, 20'h00881, 20'h9d0d2};

    scr_regs #(.VARIANT(2)) scr_regs_inst (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
        repeat (4) @(posedge aclk);
    endtask

    task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    initial begin
        #160000;
        fails++;
        conclude();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, porta_pin_in} = '0;
        s_axi_wstrb = 4'hf;
        {cfg_rc_xtal_option, cfg_wdt_always_on, sleeping, timer0_freq_out, timer1_freq_out} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // Defaults seen before any write
        rdr(scr_pkg::ADDR_SYSTEM_CONTROL_ZERO, 32'h00, scr_pkg::RESP_OKAY);
        rdr(scr_pkg::ADDR_SYSTEM_CONTROL_ONE, 32'h8a, scr_pkg::RESP_OKAY);
        rdr(scr_pkg::ADDR_DIR, 32'hff, scr_pkg::RESP_OKAY);
        chk(32'(timebase_period), 32'h400);
        chk(32'(fast_internal_rc_enable), 32'h1);
        $display("test defaults done");
        for (int i = 0; i < 16; i++) begin
            wr(scr_pkg::ADDR_SYSTEM_CONTROL_ONE, {i[3:0], 4'h5}, scr_pkg::RESP_OKAY);
            chk(32'(ext_irq_edge_mode), 32'(i[3:2]));
            chk(32'(timebase_period), 32'h1 << (10 + i[1:0]));
            chk(32'(watchdog_enable), 32'h1);
        end
        wr(scr_pkg::ADDR_SYSTEM_CONTROL_ONE, 8'h0a, scr_pkg::RESP_OKAY);
        chk(32'(watchdog_enable), 32'h0);
        cfg_wdt_always_on <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(watchdog_enable), 32'h1);
        $display("test control one done");
        cfg_rc_xtal_option <= 1'b1;
        timer1_freq_out <= 1'b1;
        wr(scr_pkg::ADDR_SYSTEM_CONTROL_ZERO, 8'hff, scr_pkg::RESP_OKAY);
        rdr(scr_pkg::ADDR_SYSTEM_CONTROL_ZERO, 32'h47, scr_pkg::RESP_OKAY);
        chk(32'({sysclk_slow_select, slow_xtal_low_power, freq_out_pin_enable}), 32'h7);
        chk(32'(fast_internal_rc_enable), 32'h0);
        chk(32'(watchdog_clk_slow), 32'h1);
        chk(32'(prog_freq_divider_out), 32'h1);
        wr(scr_pkg::ADDR_SYSTEM_CONTROL_ZERO, 8'h04, scr_pkg::RESP_OKAY);
        chk(32'({sysclk_slow_select, slow_xtal_low_power, prog_freq_divider_out}), 32'h0);
        chk(32'(fast_internal_rc_enable), 32'h1);
        cfg_rc_xtal_option <= 1'b0;
        wr(scr_pkg::ADDR_SYSTEM_CONTROL_ZERO, 8'h03, scr_pkg::RESP_OKAY);
        chk(32'({sysclk_slow_select, slow_xtal_low_power}), 32'h0);
        $display("test control zero done");
        for (int i = 0; i < 4; i++) begin
            wr(scr_pkg::ADDR_ROUTE, {4'hf, i[1:0], 2'b11}, scr_pkg::RESP_OKAY);
            rdr(scr_pkg::ADDR_ROUTE, 32'({i[1:0], 2'b00}), scr_pkg::RESP_OKAY);
            chk(32'(pin_route_sel), 32'(i[1:0]));
            chk(32'({route_irq_loc, route_timer0_loc, route_timer1_loc, route_freq_loc}),
                32'(locs[i]));
        end
        $display("test routing done");
        // Unmapped place must refuse and read zero
        wr(8'h40, 8'h55, scr_pkg::RESP_SLVERR);
        rdr(8'h40, 32'h0, scr_pkg::RESP_SLVERR);
        wr(scr_pkg::ADDR_DIR, 8'h0f, scr_pkg::RESP_OKAY);
        wr(scr_pkg::ADDR_PULLUP, 8'hff, scr_pkg::RESP_OKAY);
        chk(32'(porta_dir_input), 32'h0f);
        chk(32'(porta_pullup_active), 32'h0f);
        wr(scr_pkg::ADDR_LCDCOM, 8'h5a, scr_pkg::RESP_OKAY);
        chk(32'(soft_lcd_common_ctrl), 32'h5a);
        $display("test port controls done");
        wr(scr_pkg::ADDR_WAKE, 8'h01, scr_pkg::RESP_OKAY);
        sleeping <= 1'b1;
        porta_pin_in <= 8'h03;
        repeat (5) @(posedge aclk);
        // Unselected pin falls first: no wake expected
        porta_pin_in <= 8'h01;
        rsp = 2'b00;
        repeat (8) @(posedge aclk) rsp[0] = rsp[0] | wake_request;
        porta_pin_in <= 8'h00;
        repeat (8) @(posedge aclk) rsp[1] = rsp[1] | wake_request;
        chk(32'(rsp), 32'h2);
        $display("test wake done");
        conclude();
    end
endmodule
